// ### src/smc_top.sv
/*
 switch operating-mode controller: mode decision, watchdog, direct-input timeouts,
 sticky/latchable fault bits, fail-safe and fault status outputs.
 assumes pins arrive asynchronously; serial words arrive decoded as a one-cycle strobe on clk.
*/
`timescale 1ns/1ps
module smc_top
#(
   parameter int WD_CYC    = smc_pkg::WATCHDOG_TIMEOUT_CYC,
   parameter int IN_CYC    = smc_pkg::INPUT_TIMEOUT_CYC,
   parameter int RETRY_CYC = smc_pkg::RETRY_INTERVAL_CYC
)
(
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire logic                         clk_en,
   input  wire logic                         wake_reset_input_n,
   input  wire logic [1:0]                   direct_in,
   input  wire logic                         vdd_present,
   input  wire logic                         word_valid,
   input  wire logic [15:0]                  word_data,
   input  wire logic                         gcfg_write,
   input  wire logic [7:0]                   gcfg_wdata,
   input  wire logic [1:0]                   fault_read,
   input  wire smc_pkg::smc_chan_fault_t [1:0] chan_fault,
   input  wire smc_pkg::smc_supply_fault_t   supply_fault,
   output logic [1:0]                        channel_on,
   output logic                              serial_enable,
   output logic                              reg_access_ok,
   output logic                              normal_mode_flag,
   output smc_pkg::smc_mode_t                mode,
   output logic                              failsafe_output_n,
   output logic                              failsafe_output_oe,
   output logic                              fault_status_output_n,
   output logic [7:0]                        global_config_reg,
   output logic [1:0][5:0]                   channel_fault_reg,
   output logic [1:0]                        channel_status_reg,
   output logic [1:0]                        channel_latched
);

   if (WD_CYC < 2 || IN_CYC < 2 || RETRY_CYC < 2)
   begin : g_bad_cfg
      $error("smc_top: timeout counts must be at least 2");
   end

   // ===========================================================
   // synchronisers: pins pass two flops before any logic
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic [3:0] sync_d_reg;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_reg  <= 4'h0;
         sync2_reg  <= 4'h0;
         sync_d_reg <= 4'h0;
      end
      else if (clk_en)
      begin
         sync1_reg  <= {vdd_present, direct_in, wake_reset_input_n};
         sync2_reg  <= sync1_reg;
         sync_d_reg <= sync2_reg;
      end
   end

   wire       rst_pin   = sync2_reg[0];
   wire [1:0] din       = sync2_reg[2:1];
   wire       vdd_ok    = sync2_reg[3];
   wire       rst_rise  = sync2_reg[0] & ~sync_d_reg[0];
   wire [1:0] din_rise  = sync2_reg[2:1] & ~sync_d_reg[2:1];
   wire [1:0] din_act   = sync2_reg[2:1] ^ sync_d_reg[2:1];

   // ===========================================================
   // direct-input activity flags
   logic [1:0]       in_on_reg;
   logic [1:0][31:0] in_cnt_reg;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_in
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               in_cnt_reg[gi] <= 32'h0;
               in_on_reg[gi]  <= 1'b0;
            end
            else if (clk_en)
            begin
               if (din_act[gi] || din[gi])
               begin
                  in_cnt_reg[gi] <= 32'h0;
                  in_on_reg[gi]  <= in_on_reg[gi] | din_rise[gi];
               end
               else if (in_cnt_reg[gi] >= 32'(IN_CYC - 1))
                  in_on_reg[gi] <= 1'b0;
               else
                  in_cnt_reg[gi] <= in_cnt_reg[gi] + 32'h1;
            end
         end
      end
   endgenerate

   // ===========================================================
   // mode decision
   logic wake_reg;
   wire  wake_next = rst_pin | in_on_reg[0] | in_on_reg[1];
   wire  wake_event = (rst_rise & vdd_ok) | (|din_rise);

   logic wd_run_reg;
   logic wd_to_reg;
   logic [31:0] wd_cnt_reg;
   logic wd_last_reg;
   logic fs_reg;
   logic [7:0] gcfg_reg;

   wire watchdog_disable_bit    = gcfg_reg[smc_pkg::GCFG_WATCHDOG_DISABLE_BIT_BIT];
   wire failsafe  = (supply_fault.vdd_fail & gcfg_reg[smc_pkg::GCFG_VDD_FAIL_EN_BIT])
                  | (wd_to_reg & ~watchdog_disable_bit);

   logic [1:0] ch_fault_any;
   logic [1:0] ch_fault_off;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_fault
         assign ch_fault_off[gi] = chan_fault[gi].over_current_fault
                                 | chan_fault[gi].over_temperature_fault
                                 | chan_fault[gi].severe_short_fault;
         assign ch_fault_any[gi] = ch_fault_off[gi]
                                 | (chan_fault[gi].open_load & gcfg_reg[smc_pkg::GCFG_OL_EN_BIT])
                                 | (chan_fault[gi].short_to_supply & gcfg_reg[smc_pkg::GCFG_STS_EN_BIT])
                                 | (chan_fault[gi].clock_fail & gcfg_reg[smc_pkg::GCFG_CLKF_EN_BIT]);
      end
   endgenerate

   wire ov_q      = supply_fault.over_voltage_fault & gcfg_reg[smc_pkg::GCFG_OV_SEL_BIT];
   wire volt_flt  = supply_fault.under_voltage_fault | ov_q;
   wire fault     = (|ch_fault_off) | volt_flt;
   wire any_flt   = (|ch_fault_any) | volt_flt;

   smc_pkg::smc_mode_t mode_next;
   always_comb
   begin
      if (!wake_reg)
         mode_next = smc_pkg::SMC_SLEEP;
      else if (fault)
         mode_next = smc_pkg::SMC_FAULT;
      else if (failsafe | fs_reg)
         mode_next = smc_pkg::SMC_FAILSAFE;
      else
         mode_next = smc_pkg::SMC_NORMAL;
   end

   // fs_reg holds fail-safe until the exit handshake completes or sleep is entered, across fault episodes
   logic exit_pend_reg;
   logic [31:0] exit_cnt_reg;
   wire fs_enter  = failsafe & ~fs_reg;
   wire exit_done = fs_reg & exit_pend_reg & word_valid & ~failsafe;
   wire in_sleep  = (mode_next == smc_pkg::SMC_SLEEP);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wake_reg      <= 1'b0;
         fs_reg        <= 1'b0;
         exit_pend_reg <= 1'b0;
         exit_cnt_reg  <= 32'h0;
      end
      else if (clk_en)
      begin
         wake_reg <= wake_next | wake_event;
         if (fs_enter)
            fs_reg <= 1'b1;
         else if (exit_done || in_sleep)
            fs_reg <= 1'b0;
         if (!fs_reg || exit_done)
            exit_pend_reg <= 1'b0;
         else if (word_valid && word_data[15])
         begin
            exit_pend_reg <= 1'b1;
            exit_cnt_reg  <= 32'h0;
         end
         else if (exit_pend_reg && exit_cnt_reg >= 32'(WD_CYC - 1))
            exit_pend_reg <= 1'b0;
         else if (exit_pend_reg)
            exit_cnt_reg <= exit_cnt_reg + 32'h1;
      end
   end

   // ===========================================================
   // serial watchdog
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wd_run_reg  <= 1'b0;
         wd_to_reg   <= 1'b0;
         wd_cnt_reg  <= 32'h0;
         wd_last_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         if ((in_sleep && !rst_rise) || !vdd_ok)
         begin
            wd_run_reg <= 1'b0;
            wd_to_reg  <= 1'b0;
            wd_cnt_reg <= 32'h0;
         end
         else if (rst_rise || exit_done || (wd_run_reg && word_valid && word_data[15] != wd_last_reg))
         begin
            wd_run_reg <= 1'b1;
            wd_to_reg  <= 1'b0;
            wd_cnt_reg <= 32'h0;
         end
         else if (wd_run_reg)
         begin
            if (wd_cnt_reg >= 32'(WD_CYC - 1))
               wd_to_reg <= 1'b1;
            else
               wd_cnt_reg <= wd_cnt_reg + 32'h1;
         end
         if (word_valid)
            wd_last_reg <= word_data[15];
      end
   end

   // ===========================================================
   // registers and sticky fault bits
   wire access   = (mode_next == smc_pkg::SMC_NORMAL) & ~fs_reg;
   wire reg_wipe = in_sleep | fs_enter;

   logic [1:0] fc_d_reg;
   logic [1:0] delatch_arm_reg;
   logic [1:0] latched_reg;
   logic [1:0][3:0] retry_left_reg;
   logic [1:0][31:0] retry_cnt_reg;
   logic [1:0] retry_off_reg;
   logic [1:0][5:0] fbit_reg;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         gcfg_reg <= smc_pkg::GCFG_RESET;
      else if (clk_en)
      begin
         if (reg_wipe || exit_done)
            gcfg_reg <= smc_pkg::GCFG_RESET;
         else if (gcfg_write && access)
            gcfg_reg <= gcfg_wdata;
      end
   end

   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_ch
         wire [5:0] cause    = chan_fault[gi];
         wire       latchbl  = ch_fault_off[gi] | supply_fault.under_voltage_fault;
         wire       fc       = din[gi];
         wire       fc_rise  = fc & ~fc_d_reg[gi];
         wire       retry_on = retry_off_reg[gi] && retry_cnt_reg[gi] >= 32'(RETRY_CYC - 1);
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               fc_d_reg[gi]        <= 1'b0;
               delatch_arm_reg[gi] <= 1'b0;
               latched_reg[gi]     <= 1'b0;
               retry_left_reg[gi]  <= smc_pkg::RETRY_LIMIT_RESET;
               retry_cnt_reg[gi]   <= 32'h0;
               retry_off_reg[gi]   <= 1'b0;
               fbit_reg[gi]        <= 6'h0;
            end
            else if (clk_en)
            begin
               fc_d_reg[gi] <= fc;
               if (fs_enter)
               begin
                  latched_reg[gi]    <= 1'b0;
                  retry_left_reg[gi] <= smc_pkg::RETRY_LIMIT_RESET;
               end
               else if (latched_reg[gi] && !latchbl && (!fc || delatch_arm_reg[gi]))
               begin
                  delatch_arm_reg[gi] <= 1'b1;
                  if (delatch_arm_reg[gi] && fc_rise)
                  begin
                     latched_reg[gi]     <= 1'b0;
                     delatch_arm_reg[gi] <= 1'b0;
                     retry_left_reg[gi]  <= smc_pkg::RETRY_LIMIT_RESET;
                  end
               end
               if (latchbl && !retry_off_reg[gi] && !latched_reg[gi])
               begin
                  retry_off_reg[gi] <= 1'b1;
                  retry_cnt_reg[gi] <= 32'h0;
               end
               else if (retry_off_reg[gi])
               begin
                  retry_cnt_reg[gi] <= retry_cnt_reg[gi] + 32'h1;
                  if (retry_on)
                  begin
                     retry_off_reg[gi] <= 1'b0;
                     if (!gcfg_reg[smc_pkg::GCFG_RETRY_EN_BIT] || retry_left_reg[gi] == 4'h0)
                        latched_reg[gi] <= latchbl;
                     else
                        retry_left_reg[gi] <= retry_left_reg[gi] - 4'h1;
                  end
               end
               // wipe wins over set; on a read, set wins over clear
               if (reg_wipe || (exit_done && !latched_reg[gi]))
                  fbit_reg[gi] <= 6'h0;
               else if (fault_read[gi] && access && !latched_reg[gi] && !retry_off_reg[gi])
                  fbit_reg[gi] <= cause;
               else
                  fbit_reg[gi] <= fbit_reg[gi] | cause;
            end
         end
      end
   endgenerate

   // ===========================================================
   // outputs: channels off in sleep, faulted channel off in fault, both off on a voltage fault; direct inputs drive channels in every awake mode
   logic [1:0] ch_next;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_out
         assign ch_next[gi] = din[gi] & wake_reg & ~ch_fault_off[gi] & ~volt_flt
                            & ~latched_reg[gi] & ~retry_off_reg[gi];
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         channel_on            <= 2'h0;
         serial_enable         <= 1'b0;
         reg_access_ok         <= 1'b0;
         normal_mode_flag      <= 1'b0;
         mode                  <= smc_pkg::SMC_SLEEP;
         failsafe_output_n     <= 1'b0;
         failsafe_output_oe    <= 1'b0;
         fault_status_output_n <= 1'b0;
         global_config_reg     <= smc_pkg::GCFG_RESET;
         channel_fault_reg     <= '0;
         channel_status_reg    <= 2'h0;
         channel_latched       <= 2'h0;
      end
      else if (clk_en)
      begin
         channel_on            <= (mode_next == smc_pkg::SMC_SLEEP) ? 2'h0 : ch_next;
         serial_enable         <= ~in_sleep;
         reg_access_ok         <= access;
         normal_mode_flag      <= (mode_next == smc_pkg::SMC_NORMAL) & ~fs_reg;
         mode                  <= mode_next;
         failsafe_output_n     <= 1'b0;
         failsafe_output_oe    <= fs_reg | fs_enter;
         fault_status_output_n <= ~(any_flt | (|latched_reg));
         global_config_reg     <= gcfg_reg;
         channel_fault_reg     <= fbit_reg;
         channel_status_reg    <= ch_fault_any;
         channel_latched       <= latched_reg;
      end
   end

endmodule

// ### src/smc_pkg.sv
/*
 package for the switch operating-mode controller: timing, reset values, mode and fault carriers.
 assumes a 200 MHz core clock; long counts are overridable at the top module.
*/
// Contract
// - rising wake/reset with both supplies, or rising direct input with main supply, enters Normal.
// - each direct input's activity flag drops after 250 ms without activity.
// - sleep when both activity flags and wake/reset are low; wake is their OR.
// - wake/reset low or fail-safe: channels follow direct inputs, protections stay active.
// - mode from wake, fault, fail-safe: Sleep, Fault, Fail-safe, else Normal.
// - fail-safe raised on logic supply loss when enabled, or unmasked watchdog timeout.
// - fault raised on over-current, over-temperature, short, under-voltage, or selected over-voltage.
// - watchdog disable is global config bit 4; when set timeouts give no fail-safe.
// - sleep turns channels and serial off, registers default; sleep is power-up mode.
// - entering fail-safe drives fail-safe output low; channels follow direct inputs.
// - entering fail-safe delatches faults, resets registers except flags, blocks serial access; code also clears fault bits on entry.
// - watchdog starts on wake/reset rise with logic supply; times out without toggle.
// - word with bit 15 set, then second word within 310 ms, re-enables writes.
// - back in Normal: fail-safe output high, reset faults except latched fault bits.
// - fault status output low in real time on any fault; matching bit set.
// - fault bit sticky; read clears only when cause gone and not latched.
// - fault turns off its channel except open-load, clock-fail, short-to-supply; voltage faults both.
// - short-to-supply and open-load detection off by default; clock-fail and over-voltage on.
// - fault in fail-safe: combined mode, registers reset and blocked, direct inputs only.
// - when that fault clears, back to fail-safe, status high, no counter reset or delatch.
// - latchable fault: channel off, status low, bit set until retry turn-on, retry if enabled.
// - failure clearing before retries expire releases status but bit stays until read.
// - latched channel delatched by control term high-low-high or retry reset, at next turn-on.
// - active-low open-drain fail-safe output signals serial or logic supply loss.
package smc_pkg;

   // ===========================================================
   // timing
   localparam int CLK_MHZ                   = 200;
   localparam int WATCHDOG_TIMEOUT_TIME_MS  = 310;
   localparam int INPUT_TIMEOUT_TIME_MS     = 250;
   localparam int WATCHDOG_TIMEOUT_CYC      = WATCHDOG_TIMEOUT_TIME_MS * 1000 * CLK_MHZ;
   localparam int INPUT_TIMEOUT_CYC         = INPUT_TIMEOUT_TIME_MS * 1000 * CLK_MHZ;
   localparam int RETRY_INTERVAL_CYC        = 4096;

   // ===========================================================
   // global config layout and reset values
   localparam int GCFG_W                    = 8;
   localparam int GCFG_WATCHDOG_DISABLE_BIT_BIT           = 4;
   localparam int GCFG_OV_SEL_BIT           = 0;
   localparam int GCFG_VDD_FAIL_EN_BIT      = 1;
   localparam int GCFG_RETRY_EN_BIT         = 2;
   localparam int GCFG_OL_EN_BIT            = 3;
   localparam int GCFG_STS_EN_BIT           = 5;
   localparam int GCFG_CLKF_EN_BIT          = 6;
   localparam logic [7:0] GCFG_RESET        = 8'h41;
   localparam logic [3:0] RETRY_LIMIT_RESET = 4'h3;

   // ===========================================================
   // types
   typedef enum logic [1:0] {SMC_SLEEP, SMC_NORMAL, SMC_FAILSAFE, SMC_FAULT} smc_mode_t;

   typedef struct packed
   {
      logic over_current_fault;
      logic over_temperature_fault;
      logic severe_short_fault;
      logic open_load;
      logic short_to_supply;
      logic clock_fail;
   } smc_chan_fault_t;

   typedef struct packed
   {
      logic under_voltage_fault;
      logic over_voltage_fault;
      logic vdd_fail;
   } smc_supply_fault_t;

endpackage

// ### verification/smc_properties.sv
/*
 port-level checks for the mode controller.
 assumes a bind into smc_top; pins reach the mode decision within five clocks.
*/
`timescale 1ns/1ps
module smc_properties
(
   input wire logic                           clk,
   input wire logic                           arst_n,
   input wire logic                           wake_reset_input_n,
   input wire logic                           vdd_present,
   input wire logic [1:0]                     fault_read,
   input wire smc_pkg::smc_chan_fault_t [1:0] chan_fault,
   input wire smc_pkg::smc_supply_fault_t     supply_fault,
   input wire logic [1:0]                     channel_on,
   input wire smc_pkg::smc_mode_t             mode,
   input wire logic                           failsafe_output_oe,
   input wire logic                           fault_status_output_n,
   input wire logic [7:0]                     global_config_reg,
   input wire logic [1:0][5:0]                channel_fault_reg
);
   // ==========================================================
   // helpers
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire no_fault = (chan_fault == '0) && (supply_fault == '0);
   wire live_fault = supply_fault.under_voltage_fault || chan_fault[0].over_current_fault;
   wire in_sleep = (mode == smc_pkg::SMC_SLEEP);
   // ==========================================================
   // assertions
   a_sleep_chan_off: assert property (in_sleep [*2] |-> channel_on == 2'b00)
      else $error("channel on in sleep");
   a_uv_both_off: assert property (supply_fault.under_voltage_fault [*5] |-> ##[0:2] channel_on == 2'b00)
      else $error("channel on under low supply");
   a_fault_pin_low: assert property (live_fault [*5] |-> ##[0:2] !fault_status_output_n)
      else $error("fault status not low");
   a_fs_pin_drive: assert property ((mode == smc_pkg::SMC_FAILSAFE) [*2] |-> failsafe_output_oe)
      else $error("fail-safe pin released");
   // bits drop only after a read, never by themselves while the mode stands
   a_sticky_bit: assert property ($fell(channel_fault_reg[0][5]) && $stable(mode) && $past(mode, 2) == mode
      |-> $past(fault_read[0]) || $past(fault_read[0], 2) || $past(fault_read[0], 3))
      else $error("fault bit cleared without read");
   a_wake_normal: assert property ($rose(wake_reset_input_n) && vdd_present && no_fault && in_sleep
      |-> ##[2:6] mode == smc_pkg::SMC_NORMAL)
      else $error("no normal after wake");
   a_sleep_wake_low: assert property ($rose(in_sleep) |-> !(wake_reset_input_n && $past(wake_reset_input_n)
      && $past(wake_reset_input_n, 2) && $past(wake_reset_input_n, 3) && $past(wake_reset_input_n, 4)))
      else $error("sleep with wake high");
   a_ov_fault: assert property (supply_fault.over_voltage_fault [*5] && global_config_reg[0] && !in_sleep
      |-> ##[0:3] mode == smc_pkg::SMC_FAULT)
      else $error("no fault mode on over-voltage");
   // ==========================================================
   // covers
   c_failsafe: cover property (mode == smc_pkg::SMC_FAILSAFE && failsafe_output_oe);
   c_fault: cover property (mode == smc_pkg::SMC_FAULT);
   c_bit_clear: cover property ($fell(channel_fault_reg[0][5]));
endmodule

// ### verification/smc_host_model.sv
/*
 host model: sends a serial word every 64 clocks with the watchdog bit toggled or held.
 assumes words reach the controller already decoded as one-cycle strobes.
*/
`timescale 1ns/1ps
module smc_host_model
(
   input  wire logic   clk,
   input  wire logic   arst_n,
   input  wire logic   talk,
   input  wire logic   toggle,
   output logic        word_valid,
   output logic [15:0] word_data
);
   // ==========================================================
   // pacing well inside the watchdog window
   logic [5:0] gap_reg;
   logic       wd_bit_reg;
   wire        send        = talk && (gap_reg == 6'h3f);
   wire        wd_bit_next = toggle ? ~wd_bit_reg : wd_bit_reg;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         gap_reg    <= 6'h00;
         wd_bit_reg <= 1'b0;
         word_valid <= 1'b0;
         word_data  <= 16'h0000;
      end
      else
      begin
         gap_reg    <= gap_reg + 6'h01;
         word_valid <= send;
         // data only counts with the strobe; scrambled otherwise so stale bits cannot pass
         word_data  <= send ? {wd_bit_next, 15'h0155} : ~word_data;
         if (send)
            wd_bit_reg <= wd_bit_next;
      end
   end
endmodule

// ### verification/tb.sv
/*
 self-checking bench for the mode controller, host model on the serial side.
 assumes counts shortened to watchdog 200, input timeout 150, retry 20 clocks.
*/
`timescale 1ns/1ps
module tb;
   // ==========================================================
   // stimulus and outputs
   localparam int WD = 200;
   localparam int IN = 150;
   logic                           clk                = 1'b0;
   logic                           arst_n             = 1'b0;
   logic                           wake_reset_input_n = 1'b0;
   logic [1:0]                     direct_in          = 2'b00;
   logic                           vdd_present        = 1'b0;
   logic                           talk               = 1'b0;
   logic                           toggle             = 1'b1;
   logic                           gcfg_write         = 1'b0;
   logic [7:0]                     gcfg_wdata         = 8'h00;
   logic [1:0]                     fault_read         = 2'b00;
   smc_pkg::smc_chan_fault_t [1:0] chan_fault         = '0;
   smc_pkg::smc_supply_fault_t     supply_fault       = '0;
   logic                           word_valid;
   logic [15:0]                    word_data;
   logic [1:0]                     channel_on;
   logic                           serial_enable;
   logic                           reg_access_ok;
   logic                           normal_mode_flag;
   smc_pkg::smc_mode_t             mode;
   logic                           failsafe_output_oe;
   logic                           fault_status_output_n;
   logic [7:0]                     global_config_reg;
   logic [1:0][5:0]                channel_fault_reg;
   logic [1:0]                     channel_latched;
   int                             errors             = 0;
   int                             check_count        = 0;
   // {channels forced off, channel faults, supply faults}
   logic [16:0] kinds [5] = '{17'h08100, 17'h12000, 17'h08040, 17'h18004, 17'h18002};
   always #2.5 clk = ~clk;
   smc_host_model smc_host_model_i (.clk, .arst_n, .talk, .toggle, .word_valid, .word_data);
   smc_top #(.WD_CYC(WD), .IN_CYC(IN), .RETRY_CYC(20)) smc_top_i (.clk, .arst_n, .clk_en(1'b1),
      .wake_reset_input_n, .direct_in, .vdd_present, .word_valid, .word_data, .gcfg_write, .gcfg_wdata,
      .fault_read, .chan_fault, .supply_fault, .channel_on, .serial_enable, .reg_access_ok, .normal_mode_flag,
      .mode, .failsafe_output_n(), .failsafe_output_oe, .fault_status_output_n, .global_config_reg,
      .channel_fault_reg, .channel_status_reg(), .channel_latched);
   // ==========================================================
   // tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wait_mode(input smc_pkg::smc_mode_t m, input int lim);
      int i;
      i = 0;
      @(negedge clk);
      while (mode !== m && i < lim)
      begin
         @(negedge clk);
         i++;
      end
      check("mode", mode, m);
      if (mode !== m)
         finish_test();
   endtask
   task automatic cfg_write(input logic [7:0] v);
      tick(1);
      gcfg_wdata <= v;
      gcfg_write <= 1'b1;
      tick(1);
      gcfg_write <= 1'b0;
      tick(3);
   endtask
   // ==========================================================
   // sequence
   initial
   begin
      tick(20);
      arst_n <= 1'b1;
      tick(2);
      @(negedge clk);
      check("mode", mode, smc_pkg::SMC_SLEEP);
      check("config", global_config_reg, 8'h41);
      check("serial", serial_enable, 1'b0);
      tick(1);
      vdd_present <= 1'b1;
      wake_reset_input_n <= 1'b1;
      talk <= 1'b1;
      direct_in <= 2'b11;
      wait_mode(smc_pkg::SMC_NORMAL, 10);
      check("flag", normal_mode_flag, 1'b1);
      cfg_write(8'h45);
      check("config", global_config_reg, 8'h45);
      for (int k = 0; k < 5; k++)
      begin
         tick(1);
         {chan_fault, supply_fault} <= kinds[k][14:0];
         wait_mode(smc_pkg::SMC_FAULT, 10);
         check("status pin", fault_status_output_n, 1'b0);
         check("chan off", channel_on & kinds[k][16:15], 2'b00);
         tick(5);
         {chan_fault, supply_fault} <= 15'h0000;
         wait_mode(smc_pkg::SMC_NORMAL, 60);
         tick(60);
         @(negedge clk);
         check("status pin", fault_status_output_n, 1'b1);
      end
      check("bits 0", channel_fault_reg[0], 6'h28);
      check("bits 1", channel_fault_reg[1], 6'h10);
      check("latched", channel_latched, 2'b00);
      tick(1);
      fault_read <= 2'b11;
      tick(1);
      fault_read <= 2'b00;
      tick(3);
      @(negedge clk);
      check("bits", channel_fault_reg, 12'h000);
      tick(1);
      toggle <= 1'b0;
      wait_mode(smc_pkg::SMC_FAILSAFE, 2 * WD + 80);
      check("fs pin", failsafe_output_oe, 1'b1);
      // the config copy trails the wipe by a clock
      @(negedge clk);
      check("config", global_config_reg, 8'h41);
      check("access", reg_access_ok, 1'b0);
      cfg_write(8'h55);
      direct_in <= 2'b01;
      tick(6);
      @(negedge clk);
      check("config", global_config_reg, 8'h41);
      check("chan", channel_on, 2'b01);
      tick(1);
      toggle <= 1'b1;
      wait_mode(smc_pkg::SMC_NORMAL, 2 * WD);
      check("fs pin", failsafe_output_oe, 1'b0);
      // the second word must land before writes are honoured
      tick(WD / 2);
      cfg_write(8'h51);
      toggle <= 1'b0;
      tick(3 * WD);
      @(negedge clk);
      check("mode", mode, smc_pkg::SMC_NORMAL);
      check("config", global_config_reg, 8'h51);
      tick(1);
      toggle <= 1'b1;
      tick(70);
      cfg_write(8'h43);
      {vdd_present, supply_fault} <= 4'h1;
      wait_mode(smc_pkg::SMC_FAILSAFE, 20);
      tick(1);
      wake_reset_input_n <= 1'b0;
      direct_in <= 2'b00;
      talk <= 1'b0;
      tick(IN - 20);
      @(negedge clk);
      check("mode", mode, smc_pkg::SMC_FAILSAFE);
      wait_mode(smc_pkg::SMC_SLEEP, 60);
      check("chan", channel_on, 2'b00);
      check("serial", serial_enable, 1'b0);
      tick(1);
      direct_in <= 2'b10;
      wait_mode(smc_pkg::SMC_NORMAL, 10);
      tick(4);
      @(negedge clk);
      check("chan", channel_on, 2'b10);
      tick(1);
      direct_in <= 2'b00;
      tick(IN - 20);
      @(negedge clk);
      check("mode", mode, smc_pkg::SMC_NORMAL);
      wait_mode(smc_pkg::SMC_SLEEP, 60);
      finish_test();
   end
endmodule
bind smc_top smc_properties smc_properties_i (.clk, .arst_n, .wake_reset_input_n, .vdd_present, .fault_read,
   .chan_fault, .supply_fault, .channel_on, .mode, .failsafe_output_oe, .fault_status_output_n,
   .global_config_reg, .channel_fault_reg);
